// ===== dv/tb_tbtmc_top.sv
// Testbench for the TDM bus timing mode control block.
// Assumes the partner model on the pins; limits shortened for simulation.
`timescale 1ns/1ps
module tb_tbtmc_top;
    import tbtmc_pkg::*;
    logic           clk, rst, run, fail;
    tbtmc_req_t     req;
    logic [15:0]    rdata;
    tbtmc_pin_in_t  pins_in;
    tbtmc_pin_out_t pins_out;
    int             n_mismatch, n_checks;

    tbtmc_partner peer (.run(run), .fail(fail), .pins(pins_in));
    tbtmc_top #(.BUS_ABSENT_LIM(16'h0028), .REF_ABSENT_LIM(16'h0028),
                .SQ_HALF_LIM(16'h0014)) uut (.clk(clk), .rst(rst), .req(req),
        .rdata(rdata), .pins_in(pins_in), .pins_out(pins_out), .timing(), .base_tick());

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk) req <= '0;
        @(posedge clk) #1 chk(rdata, exp);
    endtask : rd_chk
    // pins are read only after this wait, never at the call
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic t_reset;
        rd_chk(ADDR_MCG, RST_MCG);
        rd_chk(ADDR_FR_DIV, RST_FR_DIV);
        rd_chk(16'h6006, RST_ZERO);
        settle();
        chk({15'h0000, pins_out.clk_oe | pins_out.frame_oe}, 16'h0000);
        settle();
        chk({15'h0000, pins_out.single_oe}, 16'h0000);
    endtask : t_reset
    task automatic t_mcg;
        wr(ADDR_MCG, 16'h0040);
        settle();
        chk({15'h0000, pins_out.holdover}, 16'h0001);
        wr(ADDR_MCG, 16'h0100);
        settle();
        chk({15'h0000, pins_out.holdover}, 16'h0000);
        chk({15'h0000, pins_out.secondary_8k_reference_oe}, 16'h0001);
        wr(ADDR_MCG, RST_MCG);
        settle();
        chk({15'h0000, pins_out.secondary_8k_reference_oe}, 16'h0000);
    endtask : t_mcg
    task automatic t_master;
        wr(ADDR_BUS_TYPE, 16'h0001);
        settle();
        chk({15'h0000, pins_out.clk_oe & pins_out.single_oe & pins_out.frame_oe}, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            settle();
            chk({15'h0000, pins_out.clk_inv}, {15'h0000, ~pins_out.clk_pos});
        end
        wr(ADDR_BUS_TYPE, 16'h0000);
        settle();
        chk({15'h0000, pins_out.clk_oe}, 16'h0000);
    endtask : t_master
    task automatic t_takeover;
        wr(ADDR_BUS_TYPE, 16'h0002);
        fail <= 1'b1;
        repeat (8) @(posedge clk);
        settle();
        chk({15'h0000, pins_out.clk_oe}, 16'h0000);
        wr(ADDR_PIN_IO, {14'h0000, PIN_A_IS_FAIL});
        repeat (4) @(posedge clk);
        settle();
        chk({15'h0000, pins_out.clk_oe & pins_out.frame_oe}, 16'h0001);
        fail <= 1'b0;
        wr(ADDR_BUS_TYPE, 16'h0000);
        settle();
        chk({15'h0000, pins_out.clk_oe}, 16'h0000);
    endtask : t_takeover
    // stopped bus and frozen reference: absence flags, set-wins clear, release
    task automatic t_status;
        @(posedge clk) run <= 1'b0;
        repeat (60) @(posedge clk);
        rd_chk(ADDR_STATUS, 16'h0003);
        wr(ADDR_STATUS, 16'h0001);
        rd_chk(ADDR_STATUS, 16'h0003);
        wr(ADDR_FR_DIV, 16'h0001);
        wr(ADDR_MCG, 16'h00A0);
        // let the reference run before the clear
        repeat (4) @(posedge clk);
        wr(ADDR_STATUS, 16'h0001);
        rd_chk(ADDR_STATUS, 16'h0002);
        settle();
        chk({15'h0000, pins_out.holdover}, 16'h0000);
    endtask : t_status
    task automatic summarize;
        if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        rst = 1'b1; run = 1'b1; fail = 1'b0; req = '0;
        n_mismatch = 0; n_checks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_mcg();
        t_master();
        t_takeover();
        t_status();
        summarize();
    end
    // run needs under two microseconds; far beyond that means a hang
    initial begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule : tb_tbtmc_top

// ===== dv/tbtmc_partner.sv
// Far-side model: bus timing agent, reference sources and external PLL clock.
// Assumes the bench gates the bus clocks with run and raises fail on pin A.
`timescale 1ns/1ps
module tbtmc_partner (
    // control from the bench
    input  wire logic                     run,
    input  wire logic                     fail,
    // pins toward the device
    output      tbtmc_pkg::tbtmc_pin_in_t pins
);
    import tbtmc_pkg::*;
    logic [9:0] cnt;
    logic       pll;

    initial begin
        cnt = 10'h000;
        pll = 1'b0;
        forever #3 pll = ~pll;
    end
    // stopped bus clocks freeze low, as a failed master leaves them
    always #31 if (run) cnt = cnt + 10'h001;
    assign pins = '{cnt[0] & run, cnt[0] & run, ~(cnt[0] & run), cnt[1] & run,
                    ~(&cnt[9:1]) & run, cnt[9], cnt[8], pll, fail};
endmodule : tbtmc_partner

// ===== src/tbtmc_pkg.sv
// TDM bus timing mode control: constants, register map and carrier types.
// Assumes a single 100 MHz system clock that also serves as the master clock.
package tbtmc_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses on the 16-bit register port)
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_PIN_IO   = 16'h6004;
    localparam logic [15:0] ADDR_BUS_TYPE = 16'h6010;
    localparam logic [15:0] ADDR_LOCAL    = 16'h6020;
    localparam logic [15:0] ADDR_STATUS   = 16'h6082;
    localparam logic [15:0] ADDR_MCG      = 16'h6090;
    localparam logic [15:0] ADDR_FR_DIV   = 16'h6092;
    localparam logic [15:0] ADDR_RR_LO    = 16'h60A8;
    localparam logic [15:0] ADDR_RR_HI    = 16'h60AA;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PIN_A_CFG_LSB   = 0;   // signal_pin_a_config [1:0]
    localparam int BT_MASTER       = 0;   // timing_master_select
    localparam int BT_STANDBY      = 1;   // standby_master_enable
    localparam int BT_DIFF         = 2;   // bit_clock_diff_select
    localparam int BT_DERIVE       = 3;   // bit_clock_derive_select
    localparam int BT_RATE_LSB     = 4;   // bus rate [5:4]
    localparam int BT_FTYPE_LSB    = 6;   // frame pulse type [7:6]
    localparam int MCG_CORE_SRC    = 0;   // core_clock_source_select
    localparam int MCG_DIV_LSB     = 2;   // core_clock_divider [3:2]
    localparam int MCG_PLL_REF_SOURCE_SELECT_LSB  = 4;   // pll_ref_source_select [5:4]
    localparam int MCG_HOLD_LSB    = 6;   // holdover mode [7:6]
    localparam int MCG_SEC_DRV     = 8;   // sec_ref_drive_enable
    localparam int MCG_SEC_SRC     = 9;   // sec_ref_source_select
    localparam int MCG_PHLOCK      = 10;  // standby_phase_lock_enable
    localparam int MCG_DIV_SRC     = 11;  // divider_source_select
    localparam int MCG_SEC_SQ      = 12;  // sec_ref_square_enable
    localparam int MCG_EXT_SQ      = 13;  // ext_ref_square_enable
    localparam int ST_REF_LOSS     = 0;   // pll_ref_loss_status, write 1 clears
    localparam int ST_ABSENT       = 1;   // bus_clock_absent_status
    localparam int ST_MASTER       = 2;   // master timing active

    // ------------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0]  PIN_A_IS_FAIL = 2'h3;
    localparam logic [1:0]  HOLD_LOW      = 2'h0;
    localparam logic [1:0]  HOLD_HIGH     = 2'h1;
    localparam logic [1:0]  REF_EXT       = 2'h0;
    localparam logic [1:0]  REF_SEC       = 2'h1;
    localparam logic [1:0]  REF_FREERUN   = 2'h2;
    localparam logic [1:0]  REF_RECOVER   = 2'h3;
    localparam logic [1:0]  FTYPE_NEG     = 2'h0;
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    localparam logic [15:0] RST_MCG       = 16'h0080;  // holdover follows loss
    localparam logic [15:0] RST_FR_DIV    = 16'h1000;
    localparam logic [10:0] FRAME_LAST    = 11'h7FF;   // 2048 base ticks per frame

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_NS           = 10;
    localparam int BUS_ABSENT_NS    = 250000;  // silence that flags a bus clock absent
    localparam int REF_ABSENT_NS    = 250000;  // silence that flags reference loss
    localparam int SQ_HALF_NS       = 62500;   // high half of a squared 8 kHz
    localparam int BUS_ABSENT_CYC   = (BUS_ABSENT_NS + CLK_NS - 1) / CLK_NS;
    localparam int REF_ABSENT_CYC   = (REF_ABSENT_NS + CLK_NS - 1) / CLK_NS;
    localparam int SQ_HALF_CYC      = SQ_HALF_NS / CLK_NS;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } tbtmc_req_t;

    typedef struct packed {
        logic dbl_se;     // bus_double_rate_clock, single-ended
        logic diff_pos;   // diff_clock_in_pos
        logic diff_neg;   // diff_clock_in_neg
        logic single;     // bus_single_rate_clock
        logic frame;      // bus_frame_pulse
        logic ext8k;      // external_8k_input
        logic secondary_8k_reference;      // secondary_8k_reference
        logic pll_clk;    // pll_clock_in
        logic sig_a;      // general_signal_pin_a / bus_clock_fail_in
    } tbtmc_pin_in_t;

    typedef struct packed {
        logic clk_pos;    // clock_out_pos
        logic clk_inv;    // clock_out_inverted
        logic clk_oe;
        logic single;
        logic single_oe;
        logic frame;
        logic frame_oe;
        logic secondary_8k_reference;
        logic secondary_8k_reference_oe;
        logic pll_ref;    // pll_reference_out
        logic holdover;
    } tbtmc_pin_out_t;

    typedef struct packed {
        logic dbl;
        logic single;
        logic frame;
        logic standby_frame;  // internal_standby_frame
    } tbtmc_timing_t;

    typedef struct packed {
        logic [15:0]      pin_cfg, bus_type, local_fmt, mcg, fr_div, rr_lo, rr_hi;
        logic             ref_loss, takeover;
        logic [8:0]       s1, s2, prev;
        logic [2:0]       div_cnt;
        logic [10:0]      frame_cnt;
        logic [15:0]      fr_cnt;
        logic             fr_ref;
        logic [31:0]      rr_cnt;
        logic             rr_ref;
        logic             derived_single;
        logic [3:0][15:0] act_cnt;
        logic [15:0]      sq_sec_cnt, sq_ext_cnt;
        logic             ref_d;
        logic [15:0]      rdata;
        tbtmc_pin_out_t   po;
        tbtmc_timing_t    tm;
    } tbtmc_state_t;

endpackage : tbtmc_pkg

// ===== src/tbtmc_top.sv
// TDM bus timing mode control: slave / master / standby timing, PLL reference
// selection and squaring, holdover control, bus clock and reference monitors.
// Assumes clk is the 100 MHz master clock; all pins arrive asynchronously.
`timescale 1ns/1ps

// Functional notes
// - drive secondary reference only when enabled
// - secondary output source: external or standby frame
// - slave double clock: single-ended or differential pair
// - master drives clock and inverted copy
// - slave timing follows bus clocks and frame
// - slave single clock: pin or divided double
// - unused single clock pin stays undriven
// - slave framing from bus; reference output live
// - holdover output can report reference loss
// - master drives all bus timing from core
// - core clock divided by 1,2,4,8
// - reference selector picks one of four sources
// - freerun reference divides bus clock or master
// - recovered reference divides master by two registers
// - holdover forced high, low or follows loss
// - standby: slave until bus timing fails
// - takeover needs standby and pin A fail-config
// - standby fallback may divide bus clock
// - with negative frame type, phase lock aligns standby frame within cycle
// - optional squaring of secondary reference
// - optional squaring of external reference
// - loss status set on absence, software clears
// - master clock monitors bus clock activity
// - fail input high makes standby take over
// - master rates follow bus rate setting
module tbtmc_top #(
    parameter logic [15:0] BUS_ABSENT_LIM = 16'(tbtmc_pkg::BUS_ABSENT_CYC),
    parameter logic [15:0] REF_ABSENT_LIM = 16'(tbtmc_pkg::REF_ABSENT_CYC),
    parameter logic [15:0] SQ_HALF_LIM    = 16'(tbtmc_pkg::SQ_HALF_CYC)
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // register port
    input  wire tbtmc_pkg::tbtmc_req_t    req,
    output      logic [15:0]              rdata,
    // bus and reference pins
    input  wire tbtmc_pkg::tbtmc_pin_in_t pins_in,
    output      tbtmc_pkg::tbtmc_pin_out_t pins_out,
    // timing to the rest of the TDM logic
    output      tbtmc_pkg::tbtmc_timing_t timing,
    output      logic                     base_tick
);
    import tbtmc_pkg::*;

    // ------------------------------------------------------------------
    // state and decoded controls
    // ------------------------------------------------------------------
    tbtmc_state_t s;
    tbtmc_state_t n;

    logic       master_sel, standby_en, diff_sel, derive_sel;
    logic [1:0] rate, ftype, pll_ref_source_select, hold_mode, div_sel;
    logic       master_act, fail_s, slave_dbl, prev_dbl;
    logic       dbl_edge, dbl_rise, frame_fall, src_edge;
    logic       pll_rise, sec_rise, ext_rise, ext_ref, sec_ref;
    logic [2:0] div_last;
    logic [3:0] act_edge, absent;
    logic       bus_absent, ref_absent, clr_loss;
    logic       gen_dbl, gen_single, gen_frame;

    assign master_sel = s.bus_type[BT_MASTER];
    assign standby_en = s.bus_type[BT_STANDBY];
    assign diff_sel   = s.bus_type[BT_DIFF];
    assign derive_sel = s.bus_type[BT_DERIVE];
    assign rate       = s.bus_type[BT_RATE_LSB +: 2];
    assign ftype      = s.bus_type[BT_FTYPE_LSB +: 2];
    assign pll_ref_source_select     = s.mcg[MCG_PLL_REF_SOURCE_SELECT_LSB +: 2];
    assign hold_mode  = s.mcg[MCG_HOLD_LSB +: 2];
    assign div_sel    = s.mcg[MCG_DIV_LSB +: 2];
    assign master_act = master_sel | s.takeover;

    // ------------------------------------------------------------------
    // edges of synchronised pins (only s2 and prev are looked at)
    // ------------------------------------------------------------------
    localparam int I_SE = 8, I_POS = 7, I_NEG = 6, I_SGL = 5, I_FRM = 4;
    localparam int I_EXT = 3, I_SEC = 2, I_PLL = 1, I_SIGA = 0;

    assign slave_dbl  = diff_sel ? (s.s2[I_POS] & ~s.s2[I_NEG]) : s.s2[I_SE];
    assign prev_dbl   = diff_sel ? (s.prev[I_POS] & ~s.prev[I_NEG]) : s.prev[I_SE];
    assign dbl_edge   = slave_dbl ^ prev_dbl;
    assign dbl_rise   = slave_dbl & ~prev_dbl;
    assign frame_fall = ~s.s2[I_FRM] & s.prev[I_FRM];
    assign pll_rise   = s.s2[I_PLL] & ~s.prev[I_PLL];
    assign sec_rise   = s.s2[I_SEC] & ~s.prev[I_SEC];
    assign ext_rise   = s.s2[I_EXT] & ~s.prev[I_EXT];
    assign fail_s     = s.s2[I_SIGA];

    // ------------------------------------------------------------------
    // core clock divide to base ticks
    // ------------------------------------------------------------------
    assign src_edge  = s.mcg[MCG_CORE_SRC] ? pll_rise : 1'b1;
    assign div_last  = 3'((4'h1 << div_sel) - 4'h1);
    // at-or-above, so a smaller divide takes effect at once instead of wrapping first
    assign base_tick = src_edge && (s.div_cnt >= div_last);

    // generated bus timing, one base tick per half period at the top rate
    assign gen_dbl    = s.frame_cnt[rate];
    assign gen_single = s.frame_cnt[2'(rate + 2'h1)];
    assign gen_frame  = (ftype == FTYPE_NEG) ? (s.frame_cnt != FRAME_LAST)
                                             : (s.frame_cnt == FRAME_LAST);

    // ------------------------------------------------------------------
    // activity monitors: bus double, single, frame, and reference out
    // ------------------------------------------------------------------
    assign act_edge   = {s.po.pll_ref ^ s.ref_d, (s.s2[I_FRM] ^ s.prev[I_FRM]),
                         (s.s2[I_SGL] ^ s.prev[I_SGL]), dbl_edge};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            absent[i] = (s.act_cnt[i] == ((i == 3) ? REF_ABSENT_LIM : BUS_ABSENT_LIM));
        end
    end
    assign bus_absent = |absent[2:0];
    assign ref_absent = absent[3];
    assign clr_loss   = req.wr && (req.addr == ADDR_STATUS) && req.wdata[ST_REF_LOSS];

    // squared references; a pulse reference becomes an 8 kHz square wave
    assign sec_ref = s.mcg[MCG_SEC_SQ] ? (s.sq_sec_cnt != 16'h0000) : s.s2[I_SEC];
    assign ext_ref = s.mcg[MCG_EXT_SQ] ? (s.sq_ext_cnt != 16'h0000) : s.s2[I_EXT];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        n      = s;
        n.s1   = pins_in;
        n.s2   = s.s1;
        n.prev = s.s2;
        n.ref_d = s.po.pll_ref;

        // register writes
        if (req.wr) begin
            case (req.addr)
                ADDR_PIN_IO:   n.pin_cfg   = req.wdata;
                ADDR_BUS_TYPE: n.bus_type  = req.wdata;
                ADDR_LOCAL:    n.local_fmt = req.wdata;
                ADDR_MCG:      n.mcg       = req.wdata;
                ADDR_FR_DIV:   n.fr_div    = req.wdata;
                ADDR_RR_LO:    n.rr_lo     = req.wdata;
                ADDR_RR_HI:    n.rr_hi     = req.wdata;
                default: ;
            endcase
        end

        // register reads, unmapped addresses read zero
        if (req.rd) begin
            case (req.addr)
                ADDR_PIN_IO:   n.rdata = s.pin_cfg;
                ADDR_BUS_TYPE: n.rdata = s.bus_type;
                ADDR_LOCAL:    n.rdata = s.local_fmt;
                ADDR_STATUS:   n.rdata = {13'h0000, master_act, bus_absent, s.ref_loss};
                ADDR_MCG:      n.rdata = s.mcg;
                ADDR_FR_DIV:   n.rdata = s.fr_div;
                ADDR_RR_LO:    n.rdata = s.rr_lo;
                ADDR_RR_HI:    n.rdata = s.rr_hi;
                default:       n.rdata = RST_ZERO;
            endcase
        end

        // core divider and frame counter
        if (src_edge) begin
            n.div_cnt = base_tick ? 3'h0 : 3'(s.div_cnt + 3'h1);
        end
        if (base_tick) begin
            n.frame_cnt = 11'(s.frame_cnt + 11'h001);
        end
        // standby frame tracks the bus frame while slaved with phase lock and negative frame type
        if (!master_act && s.mcg[MCG_PHLOCK] && ftype == FTYPE_NEG && frame_fall) begin
            n.frame_cnt = 11'h000;
        end

        // single clock derived from double in slave mode
        if (dbl_rise) begin
            n.derived_single = ~s.derived_single;
        end

        // freerun reference: divide bus double clock or master clock
        if (s.mcg[MCG_DIV_SRC] ? dbl_rise : 1'b1) begin
            if (s.fr_cnt >= s.fr_div) begin
                n.fr_cnt = 16'h0000;
                n.fr_ref = ~s.fr_ref;
            end else begin
                n.fr_cnt = 16'(s.fr_cnt + 16'h0001);
            end
        end

        // recovered reference: master clock by a 32-bit factor
        if (s.rr_cnt >= {s.rr_hi, s.rr_lo}) begin
            n.rr_cnt = 32'h0000_0000;
            n.rr_ref = ~s.rr_ref;
        end else begin
            n.rr_cnt = 32'(s.rr_cnt + 32'h0000_0001);
        end

        // squarers restart their high half on each rising edge
        n.sq_sec_cnt = sec_rise ? SQ_HALF_LIM
                     : (s.sq_sec_cnt != 16'h0000) ? 16'(s.sq_sec_cnt - 16'h0001) : 16'h0000;
        n.sq_ext_cnt = ext_rise ? SQ_HALF_LIM
                     : (s.sq_ext_cnt != 16'h0000) ? 16'(s.sq_ext_cnt - 16'h0001) : 16'h0000;

        // activity counters saturate at their limit
        for (int i = 0; i < 4; i++) begin
            if (act_edge[i]) begin
                n.act_cnt[i] = 16'h0000;
            end else if (!absent[i]) begin
                n.act_cnt[i] = 16'(s.act_cnt[i] + 16'h0001);
            end
        end

        // loss status: a new absence wins over a clear in the same cycle
        if (ref_absent) begin
            n.ref_loss = 1'b1;
        end else if (clr_loss) begin
            n.ref_loss = 1'b0;
        end

        // standby takeover on the fail input; dropped when standby is disabled
        if (!standby_en) begin
            n.takeover = 1'b0;
        end else if (!master_sel && s.pin_cfg[PIN_A_CFG_LSB +: 2] == PIN_A_IS_FAIL
                     && fail_s) begin
            n.takeover = 1'b1;
        end

        // pin drivers: master drives bus timing, slave leaves it undriven
        n.po.clk_oe    = master_act;
        n.po.single_oe = master_act;
        n.po.frame_oe  = master_act;
        n.po.clk_pos   = master_act & gen_dbl;
        n.po.clk_inv   = master_act & ~gen_dbl;
        n.po.single    = master_act & gen_single;
        n.po.frame     = master_act ? gen_frame : 1'b0;

        n.po.secondary_8k_reference_oe  = s.mcg[MCG_SEC_DRV];
        n.po.secondary_8k_reference     = s.mcg[MCG_SEC_DRV] &
                         (s.mcg[MCG_SEC_SRC] ? s.tm.standby_frame : s.s2[I_EXT]);

        // reference output is live in every mode
        unique case (pll_ref_source_select)
            REF_EXT:     n.po.pll_ref = ext_ref;
            REF_SEC:     n.po.pll_ref = sec_ref;
            REF_FREERUN: n.po.pll_ref = s.fr_ref;
            REF_RECOVER: n.po.pll_ref = s.rr_ref;
        endcase

        unique case (hold_mode)
            HOLD_LOW:  n.po.holdover = 1'b0;
            HOLD_HIGH: n.po.holdover = 1'b1;
            default:   n.po.holdover = s.ref_loss;
        endcase

        // internal timing: generated as master, bus-following as slave
        n.tm.standby_frame = (s.frame_cnt == FRAME_LAST);
        n.tm.dbl    = master_act ? gen_dbl : slave_dbl;
        n.tm.single = master_act ? gen_single
                    : (derive_sel ? s.derived_single : s.s2[I_SGL]);
        n.tm.frame  = master_act ? gen_frame : s.s2[I_FRM];
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.mcg      <= RST_MCG;
            s.fr_div   <= RST_FR_DIV;
        end else begin
            s <= n;
        end
    end

    assign rdata    = s.rdata;
    assign pins_out = s.po;
    assign timing   = s.tm;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_sec_drive;
        @(posedge clk) disable iff (rst)
        !s.mcg[MCG_SEC_DRV] |=> !pins_out.secondary_8k_reference_oe && !pins_out.secondary_8k_reference;
    endproperty
    a_sec_drive: assert property (p_sec_drive) else $error("sec ref driven while off");

    property p_inv_clock;
        @(posedge clk) disable iff (rst)
        pins_out.clk_oe |-> (pins_out.clk_inv == !pins_out.clk_pos);
    endproperty
    a_inv_clock: assert property (p_inv_clock) else $error("inverted clock mismatch");

    property p_slave_undriven;
        @(posedge clk) disable iff (rst)
        (!master_sel && !s.takeover) [*2] |-> !pins_out.single_oe && !pins_out.frame_oe;
    endproperty
    a_slave_undriven: assert property (p_slave_undriven) else $error("slave drives bus");

    property p_hold_force;
        @(posedge clk) disable iff (rst)
        (hold_mode == HOLD_HIGH) [*2] |-> pins_out.holdover;
    endproperty
    a_hold_force: assert property (p_hold_force) else $error("holdover not forced");

    property p_takeover;
        @(posedge clk) disable iff (rst)
        standby_en && !master_sel && fail_s && s.pin_cfg[1:0] == PIN_A_IS_FAIL
        |=> s.takeover ##1 pins_out.clk_oe;
    endproperty
    a_takeover: assert property (p_takeover) else $error("standby did not take over");

    property p_loss_set_wins;
        @(posedge clk) disable iff (rst)
        ref_absent && clr_loss |=> s.ref_loss ##1 (hold_mode != 2'h2 || pins_out.holdover);
    endproperty
    a_loss_set_wins: assert property (p_loss_set_wins) else $error("loss clear won");

    property p_phase_lock;
        @(posedge clk) disable iff (rst)
        !master_act && s.mcg[MCG_PHLOCK] && ftype == FTYPE_NEG && frame_fall
        |=> s.frame_cnt == 11'h000;
    endproperty
    a_phase_lock: assert property (p_phase_lock) else $error("standby frame not aligned");

    property p_recover_sel;
        @(posedge clk) disable iff (rst)
        pll_ref_source_select == REF_RECOVER |=> pins_out.pll_ref == $past(s.rr_ref);
    endproperty
    a_recover_sel: assert property (p_recover_sel) else $error("reference select wrong");

    property p_divide_one;
        @(posedge clk) disable iff (rst)
        !s.mcg[MCG_CORE_SRC] && div_sel == 2'h0 |-> base_tick;
    endproperty
    a_divide_one: assert property (p_divide_one) else $error("divide by one lost ticks");

endmodule : tbtmc_top
